/* ssrc_ext_ctl.sv */
module ssrc_ext_ctl (
    input  wire        i_clk,    // Controller clock
    output logic [7:0] o_sel,    // Select code lines
    output logic       o_strobe  // Valid line
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_sel = 8'h00;
        o_strobe = 1'b0;
    end
    task automatic select(input logic [7:0] code, input int slow);
        @(posedge i_clk);
        o_sel <= code;
        repeat (4 + slow) @(posedge i_clk);
        o_strobe <= 1'b1;
        repeat (4) @(posedge i_clk);
        o_strobe <= 1'b0;
        repeat (2) @(posedge i_clk);
        // Lines are let go after the hold; the inverse exposes a latch that keeps sampling
        o_sel <= ~code;
    endtask
endmodule

/* ssrc_map.vh */
`ifndef SSRC_MAP_VH
`define SSRC_MAP_VH
// Register offsets (word index on the plain port)
`define SSRC_REG_CTRL      4'h0
`define SSRC_REG_LOOPS     4'h1
`define SSRC_REG_CMD       4'h2
`define SSRC_REG_STATUS    4'h3
`define SSRC_REG_SEG0      4'h4
`define SSRC_REG_SEG1      4'h5
// CTRL field positions
`define SSRC_CTRL_MODE_LSB 0
`define SSRC_CTRL_ARMED    2
`define SSRC_CTRL_ENSRC_LSB 3
`define SSRC_CTRL_INSRC_LSB 5
`define SSRC_CTRL_EXTSEL   7
`define SSRC_CTRL_IMMED    8
// Run modes
`define SSRC_MODE_CONT     2'h0
`define SSRC_MODE_TRIG     2'h1
`define SSRC_MODE_GATE     2'h2
// Enable sources
`define SSRC_EN_BUS        2'h0
`define SSRC_EN_EVENT      2'h1
`define SSRC_EN_TRIG       2'h2
// Initiate sources
`define SSRC_IN_FP         2'h0
`define SSRC_IN_BUS        2'h1
`define SSRC_IN_TRIG       2'h2
`define SSRC_IN_EVENT      2'h3
// CMD bits (write-one pulses)
`define SSRC_CMD_ENABLE    0
`define SSRC_CMD_INIT      1
`define SSRC_CMD_ABORT     2
// Reset values and loop count limit
`define SSRC_CTRL_RST      9'h000
`define SSRC_LOOPS_RST     20'h00001
`define SSRC_LOOPS_MAX     20'hF4240
`define SSRC_SEG_RST       8'h00
`endif

/* ssrc_sel_chan.v */
`include "ssrc_map.vh"
// One channel of external segment select: sync, strobe edge, latch, apply.
module ssrc_sel_chan #(
    parameter SEG_W = 8
) (
    input  wire             i_clk,       // Sample clock
    input  wire             i_rst,       // Async reset, high
    input  wire [SEG_W-1:0] i_sel,       // Select code pins
    input  wire             i_strobe,    // Valid strobe pin
    input  wire             i_ext_en,    // External control selected
    input  wire             i_immed,     // Immediate switching
    input  wire             i_seg_end,   // Current segment finishes
    input  wire [SEG_W-1:0] i_bus_seg,   // Segment from register
    output reg  [SEG_W-1:0] o_seg,       // Playing segment index
    output reg              o_pending    // Change waiting for segment end
);
    reg [SEG_W-1:0] sel_s1_r, sel_s2_r, sel_s3_r;
    reg [2:0]       stb_r;
    reg             stb_q_r;
    reg [SEG_W-1:0] want_r;
    wire            stb_lvl = (stb_r[1] == stb_r[2]) ? stb_r[1] : stb_q_r;
    wire            stb_rise = stb_lvl & ~stb_q_r;
    wire            sel_ok = (sel_s2_r == sel_s3_r);
    wire [SEG_W-1:0] target = i_ext_en ? want_r : i_bus_seg;

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sel_s1_r  <= {SEG_W{1'b0}};
            sel_s2_r  <= {SEG_W{1'b0}};
            sel_s3_r  <= {SEG_W{1'b0}};
            stb_r     <= 3'h0;
            stb_q_r   <= 1'b0;
            want_r    <= `SSRC_SEG_RST;
            o_seg     <= `SSRC_SEG_RST;
            o_pending <= 1'b0;
        end else begin
            sel_s1_r <= i_sel;
            sel_s2_r <= sel_s1_r;
            sel_s3_r <= sel_s2_r;
            stb_r    <= {stb_r[1:0], i_strobe};
            stb_q_r  <= stb_lvl;
            // Code is the binary value; all-zero is index 0, all-ones 255
            if (stb_rise && sel_ok)
                want_r <= sel_s3_r;
            // Undriven pins read low and so land on segment 0
            if (target != o_seg) begin
                if (i_immed || i_seg_end) begin
                    o_seg     <= target;
                    o_pending <= 1'b0;
                end else begin
                    o_pending <= 1'b1;
                end
            end else begin
                o_pending <= 1'b0;
            end
        end
    end
endmodule

/* ssrc_top.v */
`include "ssrc_map.vh"
module ssrc_top #(
    parameter SEG_W  = 8,
    parameter LOOP_W = 20
) (
    input  wire             i_clk,        // Sample clock, 100 MHz
    input  wire             i_rst,        // Async reset, high
    input  wire [3:0]       i_addr,       // Register index
    input  wire [31:0]      i_wdata,      // Write data
    input  wire             i_wr,         // Write strobe
    input  wire             i_rd,         // Read strobe
    output reg  [31:0]      o_rdata,      // Read data, cycle after i_rd
    input  wire [SEG_W-1:0] i_sel0,       // Channel 0 select pins
    input  wire             i_strobe0,    // Channel 0 valid strobe
    input  wire [SEG_W-1:0] i_sel1,       // Channel 1 select pins
    input  wire             i_strobe1,    // Channel 1 valid strobe
    input  wire             i_trig,       // Trigger input pin
    input  wire             i_event,      // Event input pin
    input  wire             i_fp_init,    // Front-panel initiate pin
    input  wire             i_fp_abort,   // Front-panel abort pin
    input  wire             i_seg_end,    // Playing segment reached end
    output reg              o_play,       // Output generating waveform
    output reg              o_hold_dc,    // Output held at first point
    output wire [SEG_W-1:0] o_seg0,       // Channel 0 segment index
    output wire [SEG_W-1:0] o_seg1        // Channel 1 segment index
);
    localparam ST_IDLE = 3'b001;
    localparam ST_RUN  = 3'b010;
    localparam ST_WAIT = 3'b100;

    reg [8:0]        ctrl_r;
    reg [LOOP_W-1:0] loops_r;
    reg [SEG_W-1:0]  bus_seg0_r, bus_seg1_r;
    reg [2:0]        state_r, state_nxt;
    reg [LOOP_W-1:0] left_r, left_nxt;
    reg              enabled_r, enabled_nxt;
    reg              cmd_en_r, cmd_init_r, cmd_abort_r;
    reg [2:0]        trig_r, evt_r, fpi_r, fpa_r;
    reg              trig_q_r, evt_q_r, fpi_q_r, fpa_q_r;
    wire             pend0, pend1;

    wire [1:0] mode   = ctrl_r[`SSRC_CTRL_MODE_LSB+1:`SSRC_CTRL_MODE_LSB];
    wire       armed  = ctrl_r[`SSRC_CTRL_ARMED];
    wire [1:0] en_src = ctrl_r[`SSRC_CTRL_ENSRC_LSB+1:`SSRC_CTRL_ENSRC_LSB];
    wire [1:0] in_src = ctrl_r[`SSRC_CTRL_INSRC_LSB+1:`SSRC_CTRL_INSRC_LSB];

    // Debounced levels: accept a change only when stages two and three agree
    wire trig_l = (trig_r[1] == trig_r[2]) ? trig_r[1] : trig_q_r;
    wire evt_l  = (evt_r[1] == evt_r[2]) ? evt_r[1] : evt_q_r;
    wire fpi_l  = (fpi_r[1] == fpi_r[2]) ? fpi_r[1] : fpi_q_r;
    wire fpa_l  = (fpa_r[1] == fpa_r[2]) ? fpa_r[1] : fpa_q_r;
    wire evt_edge  = evt_l ^ evt_q_r;
    wire trig_rise = trig_l & ~trig_q_r;
    wire fpi_rise  = fpi_l & ~fpi_q_r;
    wire fpa_rise  = fpa_l & ~fpa_q_r;

    reg enable_ev, init_ev, abort_ev;
    always @* begin
        case (en_src)
            `SSRC_EN_BUS:   enable_ev = cmd_en_r;
            `SSRC_EN_EVENT: enable_ev = evt_edge;
            `SSRC_EN_TRIG:  enable_ev = trig_rise;
            default:        enable_ev = 1'b0;
        endcase
        case (in_src)
            `SSRC_IN_FP:    init_ev = fpi_rise;
            `SSRC_IN_BUS:   init_ev = cmd_init_r;
            `SSRC_IN_TRIG:  init_ev = trig_rise;
            `SSRC_IN_EVENT: init_ev = evt_edge;
            default:        init_ev = 1'b0;
        endcase
        // Self-armed ignores aborts altogether
        abort_ev = armed & (cmd_abort_r | fpa_rise);
    end

    // Gate level from the initiate input; only trigger or event are legal
    wire gate_lvl = (in_src == `SSRC_IN_TRIG)  ? trig_l :
                    (in_src == `SSRC_IN_EVENT) ? evt_l : 1'b0;

    always @* begin
        state_nxt   = state_r;
        left_nxt    = left_r;
        enabled_nxt = enabled_r;
        if (!armed)
            enabled_nxt = 1'b1;
        else if (enable_ev)
            enabled_nxt = 1'b1;
        case (state_r)
            ST_IDLE: begin
                if (mode == `SSRC_MODE_CONT && enabled_nxt)
                    state_nxt = ST_RUN;
                else if (mode == `SSRC_MODE_TRIG && armed && init_ev) begin
                    state_nxt = ST_RUN;
                    left_nxt  = loops_r;
                end else if (mode == `SSRC_MODE_GATE && armed && gate_lvl)
                    state_nxt = ST_RUN;
            end
            ST_RUN: begin
                if (mode == `SSRC_MODE_GATE && !gate_lvl)
                    state_nxt = ST_IDLE;
                else if (mode == `SSRC_MODE_TRIG && i_seg_end) begin
                    if (left_r <= {{(LOOP_W-1){1'b0}}, 1'b1})
                        state_nxt = ST_WAIT;
                    else
                        left_nxt = left_r - {{(LOOP_W-1){1'b0}}, 1'b1};
                end else if (mode == `SSRC_MODE_CONT && !enabled_nxt)
                    state_nxt = ST_IDLE;
            end
            ST_WAIT: state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
        if (abort_ev) begin
            state_nxt   = ST_IDLE;
            enabled_nxt = 1'b0;
        end
    end

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl_r      <= `SSRC_CTRL_RST;
            loops_r     <= `SSRC_LOOPS_RST;
            bus_seg0_r  <= `SSRC_SEG_RST;
            bus_seg1_r  <= `SSRC_SEG_RST;
            state_r     <= ST_IDLE;
            left_r      <= {LOOP_W{1'b0}};
            enabled_r   <= 1'b0;
            cmd_en_r    <= 1'b0;
            cmd_init_r  <= 1'b0;
            cmd_abort_r <= 1'b0;
            trig_r      <= 3'h0;
            evt_r       <= 3'h0;
            fpi_r       <= 3'h0;
            fpa_r       <= 3'h0;
            trig_q_r    <= 1'b0;
            evt_q_r     <= 1'b0;
            fpi_q_r     <= 1'b0;
            fpa_q_r     <= 1'b0;
            o_rdata     <= 32'h0000_0000;
            o_play      <= 1'b0;
            o_hold_dc   <= 1'b0;
        end else begin
            trig_r   <= {trig_r[1:0], i_trig};
            evt_r    <= {evt_r[1:0], i_event};
            fpi_r    <= {fpi_r[1:0], i_fp_init};
            fpa_r    <= {fpa_r[1:0], i_fp_abort};
            trig_q_r <= trig_l;
            evt_q_r  <= evt_l;
            fpi_q_r  <= fpi_l;
            fpa_q_r  <= fpa_l;
            state_r   <= state_nxt;
            left_r    <= left_nxt;
            enabled_r <= enabled_nxt;
            cmd_en_r    <= i_wr && i_addr == `SSRC_REG_CMD && i_wdata[`SSRC_CMD_ENABLE];
            cmd_init_r  <= i_wr && i_addr == `SSRC_REG_CMD && i_wdata[`SSRC_CMD_INIT];
            cmd_abort_r <= i_wr && i_addr == `SSRC_REG_CMD && i_wdata[`SSRC_CMD_ABORT];
            if (i_wr) begin
                case (i_addr)
                    `SSRC_REG_CTRL:  ctrl_r <= i_wdata[8:0];
                    // Out-of-range counts clamp into 1..1M
                    `SSRC_REG_LOOPS: begin
                        if (i_wdata[LOOP_W-1:0] == {LOOP_W{1'b0}})
                            loops_r <= `SSRC_LOOPS_RST;
                        else if (i_wdata[31:0] > {12'h000, `SSRC_LOOPS_MAX})
                            loops_r <= `SSRC_LOOPS_MAX;
                        else
                            loops_r <= i_wdata[LOOP_W-1:0];
                    end
                    `SSRC_REG_SEG0:  bus_seg0_r <= i_wdata[SEG_W-1:0];
                    `SSRC_REG_SEG1:  bus_seg1_r <= i_wdata[SEG_W-1:0];
                    default: ;
                endcase
            end
            if (i_rd) begin
                case (i_addr)
                    `SSRC_REG_CTRL:   o_rdata <= {23'h000000, ctrl_r};
                    `SSRC_REG_LOOPS:  o_rdata <= {12'h000, loops_r};
                    `SSRC_REG_STATUS: o_rdata <= {24'h000000, pend1, pend0,
                                                  enabled_r, o_hold_dc, o_play, state_r};
                    `SSRC_REG_SEG0:   o_rdata <= {24'h000000, o_seg0};
                    `SSRC_REG_SEG1:   o_rdata <= {24'h000000, o_seg1};
                    default:          o_rdata <= 32'h0000_0000;
                endcase
            end else begin
                o_rdata <= 32'h0000_0000;
            end
            o_play    <= (state_nxt == ST_RUN);
            // Armed idle sits on the first point; self-armed idles on the wave
            o_hold_dc <= armed && (state_nxt != ST_RUN);
        end
    end

    // Channels run independently; keeping them aligned is up to the caller
    ssrc_sel_chan #(.SEG_W(SEG_W)) u_ch0 (
        .i_clk     (i_clk),
        .i_rst     (i_rst),
        .i_sel     (i_sel0),
        .i_strobe  (i_strobe0),
        .i_ext_en  (ctrl_r[`SSRC_CTRL_EXTSEL]),
        .i_immed   (ctrl_r[`SSRC_CTRL_IMMED]),
        .i_seg_end (i_seg_end),
        .i_bus_seg (bus_seg0_r),
        .o_seg     (o_seg0),
        .o_pending (pend0)
    );
    ssrc_sel_chan #(.SEG_W(SEG_W)) u_ch1 (
        .i_clk     (i_clk),
        .i_rst     (i_rst),
        .i_sel     (i_sel1),
        .i_strobe  (i_strobe1),
        .i_ext_en  (ctrl_r[`SSRC_CTRL_EXTSEL]),
        .i_immed   (ctrl_r[`SSRC_CTRL_IMMED]),
        .i_seg_end (i_seg_end),
        .i_bus_seg (bus_seg1_r),
        .o_seg     (o_seg1),
        .o_pending (pend1)
    );
endmodule

/* ssrc_top_assertions.sv */
module ssrc_top_chk #(
    parameter SEG_W  = 8,
    parameter LOOP_W = 20
) (
    input wire             i_clk,      // Sample clock
    input wire             i_rst,      // Async reset
    input wire [3:0]       i_addr,     // Register index
    input wire [31:0]      i_wdata,    // Write data
    input wire             i_wr,       // Write strobe
    input wire             i_rd,       // Read strobe
    input wire [31:0]      o_rdata,    // Read data
    input wire             i_seg_end,  // Segment end
    input wire             o_play,     // Generating
    input wire             o_hold_dc,  // Held at first point
    input wire [SEG_W-1:0] o_seg0,     // Channel 0 segment
    input wire [SEG_W-1:0] o_seg1      // Channel 1 segment
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // Shadow of the control word, kept from bus writes only
    logic [8:0] ctrl_r;
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst)
            ctrl_r <= 9'h000;
        else if (i_wr && i_addr == 4'h0)
            ctrl_r <= i_wdata[8:0];
    end
    seg0_coh_a: assert property ($changed(o_seg0) && !ctrl_r[8] && !$past(ctrl_r[8])
        |-> $past(i_seg_end)) else $error("channel 0 switched mid segment");
    seg1_coh_a: assert property ($changed(o_seg1) && !ctrl_r[8] && !$past(ctrl_r[8])
        |-> $past(i_seg_end)) else $error("channel 1 switched mid segment");
    play_hold_a: assert property (!(o_play && o_hold_dc))
        else $error("play and hold together");
    hold_arm_a: assert property (o_hold_dc |-> $past(ctrl_r[2]))
        else $error("hold while self armed");
    self_run_a: assert property (ctrl_r[2:0] == 3'h0 && $past(ctrl_r[2:0]) == 3'h0
        && $past(o_play) |-> o_play) else $error("self armed playback stopped");
    rst_play_a: assert property ($fell(i_rst) |-> ##[1:2] o_play)
        else $error("no playback after reset");
    rst_seg_a: assert property ($fell(i_rst) |-> o_seg0 == 8'h00 && o_seg1 == 8'h00
        && !o_hold_dc) else $error("bad state after reset");
    stat_a: assert property ($past(i_rd) && $past(i_addr) == 4'h3
        |-> o_rdata[4:3] == $past({o_hold_dc, o_play})) else $error("status flags wrong");
    cover property ($rose(o_play) && ctrl_r[1:0] == 2'h1);
    cover property ($fell(o_play) && ctrl_r[1:0] == 2'h2);
    cover property ($changed(o_seg0) && ctrl_r[8]);
endmodule
bind ssrc_top ssrc_top_chk #(.SEG_W(SEG_W), .LOOP_W(LOOP_W)) chk_u (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_seg_end(i_seg_end), .o_play(o_play),
    .o_hold_dc(o_hold_dc), .o_seg0(o_seg0), .o_seg1(o_seg1));

/* tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, rd_pend = 1'b0;
    logic [4:0]  pin = 5'h00;  // trig, event, fp_init, fp_abort, seg_end
    logic [3:0]  i_addr = 4'h0;
    logic [31:0] i_wdata = 32'h0, o_rdata;
    logic [7:0]  o_seg0, o_seg1, code;
    logic        o_play, o_hold_dc;
    logic [63:0] exp_q[$], ent;
    wire  [7:0]  i_sel0, i_sel1;
    wire         i_strobe0, i_strobe1;
    int          err_total = 0, checks = 0;
    always #5 i_clk = ~i_clk;
    ssrc_ext_ctl ctl0_u (.i_clk(i_clk), .o_sel(i_sel0), .o_strobe(i_strobe0));
    ssrc_ext_ctl ctl1_u (.i_clk(i_clk), .o_sel(i_sel1), .o_strobe(i_strobe1));
    // One segment-end line feeds both channels, as equal-length segments keep them in step
    ssrc_top dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sel0(i_sel0), .i_strobe0(i_strobe0),
        .i_sel1(i_sel1), .i_strobe1(i_strobe1), .i_trig(pin[0]), .i_event(pin[1]),
        .i_fp_init(pin[2]), .i_fp_abort(pin[3]), .i_seg_end(pin[4]), .o_play(o_play),
        .o_hold_dc(o_hold_dc), .o_seg0(o_seg0), .o_seg1(o_seg1));
    task automatic complete_run;
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic cmpb(input string nm, input logic e, input logic g);
        cmp(nm, {31'h0, e}, {31'h0, g});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        exp_q.push_back({m, e});
        @(posedge i_clk);
        i_rd <= 1'b0;
    endtask
    task automatic pulse(input int b, input int n);
        @(posedge i_clk);
        pin[b] <= 1'b1;
        repeat (n) @(posedge i_clk);
        pin[b] <= 1'b0;
    endtask
    always @(posedge i_clk) rd_pend <= i_rd;
    always @(negedge i_clk) begin
        if (rd_pend) begin
            ent = exp_q.pop_front();
            cmp("rdata", ent[31:0], o_rdata & ent[63:32]);
        end
    end
    // Whole run is under a thousand cycles; ten thousand means a hang
    initial begin
        #100000;
        err_total++;
        complete_run();
    end
    initial begin
        void'($urandom(77));
        cyc(12);
        i_rst <= 1'b0;
        cyc(3);
        cmpb("play", 1'b1, o_play);
        rd(4'h0, 32'h0, 32'h1FF);
        rd(4'h1, 32'h1, 32'hFFFFF);
        wr(4'hF, 32'hFFFFFFFF);
        rd(4'hF, 32'h0, 32'hFFFFFFFF);
        wr(4'h0, 32'h180);
        for (int k = 0; k < 4; k++) begin
            code = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($urandom);
            ctl0_u.select(code, k);
            ctl1_u.select(~code, 0);
            cyc(6);
            rd(4'h4, {24'h0, code}, 32'hFF);
            rd(4'h5, {24'h0, ~code}, 32'hFF);
        end
        wr(4'h0, 32'h080);
        ctl0_u.select(8'h5A, 2);
        cyc(6);
        rd(4'h4, {24'h0, code}, 32'hFF);
        rd(4'h3, 32'h40, 32'h40);
        pulse(4, 1);
        cyc(2);
        rd(4'h4, 32'h5A, 32'hFF);
        wr(4'h0, 32'h000);
        wr(4'h2, 32'h4);
        pulse(3, 3);
        cyc(6);
        cmpb("play", 1'b1, o_play);
        wr(4'h0, 32'h00C);
        // Arming while running keeps the enable; an abort drops it so the enable must come again
        wr(4'h2, 32'h4);
        wr(4'h2, 32'h1);
        cyc(4);
        cmpb("hold", 1'b1, o_hold_dc);
        cmpb("play", 1'b0, o_play);
        pin[1] <= 1'b1;
        cyc(8);
        cmpb("play", 1'b1, o_play);
        wr(4'h2, 32'h4);
        cyc(3);
        cmpb("play", 1'b0, o_play);
        pin[1] <= 1'b0;
        wr(4'h1, 32'h0);
        rd(4'h1, 32'h1, 32'hFFFFF);
        wr(4'h1, 32'hFFFFF);
        rd(4'h1, 32'hF4240, 32'hFFFFF);
        wr(4'h1, 32'h2);
        wr(4'h0, 32'h025);
        // The falling event edge re-enabled continuous play; stop it before the trigger tests
        wr(4'h2, 32'h4);
        pulse(2, 3);
        cyc(8);
        cmpb("play", 1'b0, o_play);
        wr(4'h2, 32'h2);
        cyc(2);
        cmpb("play", 1'b1, o_play);
        pulse(4, 1);
        cyc(2);
        cmpb("play", 1'b1, o_play);
        pulse(4, 1);
        cyc(4);
        cmpb("play", 1'b0, o_play);
        wr(4'h0, 32'h045);
        pulse(0, 5);
        cyc(8);
        cmpb("play", 1'b1, o_play);
        wr(4'h2, 32'h4);
        cyc(3);
        cmpb("play", 1'b0, o_play);
        wr(4'h0, 32'h066);
        pin[1] <= 1'b1;
        cyc(8);
        cmpb("play", 1'b1, o_play);
        pin[1] <= 1'b0;
        cyc(8);
        cmpb("play", 1'b0, o_play);
        cyc(4);
        complete_run();
    end
endmodule
